// file: verilog/usb_host_irq_enable_frame_index.sv
// Interrupt-enable mask and microframe index registers of a host controller
// Assumes a single-cycle register port; status flags kept elsewhere
//
// Summary of operation
// - Enabled active source raises host interrupt.
// - Disabled sources still appear in status.
// - Async advance waits for threshold tick.
// - System error interrupts immediately.
// - Rollover interrupts immediately.
// - Port change interrupts immediately.
// - Transfer error waits for threshold tick.
// - Transfer done waits for threshold tick.
// - Index increments every 125 us microframe.
// - Frame number is index bits 13:3.
// - List index is bits N:3.
// - List size code selects N.
// - Index writes accepted only while halted.
// - Index write changes later frame numbers.
// - Rollover event when list index wraps.
`timescale 1ns/1ps
`include "usb_host_irq_regs.svh"

module usb_host_irq_enable_frame_index
  import usb_host_irq_pkg::*;
(
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         clock_enable,
  input  wire reg_request_type              request,
  output logic [31:0]                       read_data,
  output logic                              read_valid,
  input  wire irq_flags_type                status_flags,
  input  wire logic                         halted_flag,
  input  wire logic                         run_stop,
  input  wire logic [1:0]                   list_size_sel,
  input  wire logic                         threshold_tick,
  output logic                              host_irq,
  output logic                              rollover_event,
  output logic [`SOF_WIDTH-1:0]             sof_frame_number,
  output logic [`LIST_INDEX_WIDTH-1:0]      list_index,
  output logic                              microframe_end
);

  // ----------------------------------------------------------------
  // Shared functions
  // ----------------------------------------------------------------
  // Top index bit N for a list size code
  function automatic logic [3:0] top_bit(input logic [1:0] code);
    logic [3:0] result;
    result = 4'(`TOP_BIT_1024);
    if (code == `LIST_SIZE_512) begin
      result = 4'(`TOP_BIT_512);
    end else if (code == `LIST_SIZE_256) begin
      result = 4'(`TOP_BIT_256);
    end
    return result;
  endfunction : top_bit

  // Register hit for one offset
  function automatic logic is_offset(
    input logic [7:0] address,
    input logic [7:0] offset
  );
    return (address == offset);
  endfunction : is_offset

  // Bits N:3 of an index, right aligned
  function automatic logic [`LIST_INDEX_WIDTH-1:0] list_bits(
    input logic [`INDEX_WIDTH-1:0] index,
    input logic [1:0]              code
  );
    logic [`INDEX_WIDTH-1:0] shifted;
    logic [`INDEX_WIDTH-1:0] mask;
    shifted = index >> `SOF_LSB;
    mask    = ~(`INDEX_MAX << (top_bit(code) - 4'(`SOF_LSB) + 4'h1));
    return `LIST_INDEX_WIDTH'(shifted & mask);
  endfunction : list_bits

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [`IRQ_FIELD_WIDTH-1:0] irq_enable_mask;
  logic [`INDEX_WIDTH-1:0]     microframe_index;
  logic [`IRQ_FIELD_WIDTH-1:0] gated_pending;
  counter_state_type           state;
  counter_state_type           next_state;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire hit_mask  = is_offset(request.address, `OFFSET_IRQ_ENABLE_MASK);
  wire hit_index = is_offset(request.address, `OFFSET_MICROFRAME_INDEX);
  wire full_word = (request.byte_enable == 4'hF);

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire write_mask  = clock_enable && request.write && hit_mask;
  wire write_index = clock_enable && request.write && hit_index && halted_flag
                     && full_word;

  wire [`INDEX_WIDTH-1:0] written_index = request.write_data[`INDEX_MSB:0];

  // ----------------------------------------------------------------
  // Frame counter
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      counter_stopped: begin
        if (run_stop && !halted_flag) begin
          next_state = counter_running;
        end
      end
      counter_running: begin
        if (!run_stop || halted_flag) begin
          next_state = counter_stopped;
        end
      end
      default: begin
        next_state = counter_stopped;
      end
    endcase
  end

  wire running = (state == counter_running);

  microframe_timer i_microframe_timer (
    .clock     (clock),
    .rst       (rst),
    .enable    (clock_enable),
    .run       (running),
    .frame_end (microframe_end)
  );

  wire [`INDEX_WIDTH-1:0] incremented =
    (microframe_index == `INDEX_MAX) ? `RESET_INDEX : microframe_index + 14'h0001;
  wire advance = clock_enable && microframe_end;

  wire list_wrap = advance
    && (list_bits(incremented, list_size_sel) == `LIST_INDEX_WIDTH'(0))
    && (incremented[`SOF_LSB-1:0] == 3'h0);

  always_ff @(posedge clock) begin
    if (rst) begin
      state <= counter_stopped;
    end else if (clock_enable) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Frame index next value
  // ----------------------------------------------------------------
  logic [`INDEX_WIDTH-1:0] next_microframe_index;

  always_comb begin
    next_microframe_index = microframe_index;
    if (write_index) begin
      next_microframe_index = written_index;
    end else if (advance) begin
      next_microframe_index = incremented;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      microframe_index <= `RESET_INDEX;
    end else begin
      microframe_index <= next_microframe_index;
    end
  end

  // ----------------------------------------------------------------
  // Rollover event
  // ----------------------------------------------------------------
  // Pulse only; the flag itself lives in the status register
  always_ff @(posedge clock) begin
    if (rst) begin
      rollover_event <= 1'b0;
    end else begin
      rollover_event <= list_wrap;
    end
  end

  // ----------------------------------------------------------------
  // Frame number and list index outputs
  // ----------------------------------------------------------------
  // frame number bits 13:3
  always_ff @(posedge clock) begin
    if (rst) begin
      sof_frame_number <= `SOF_WIDTH'(0);
    end else if (clock_enable) begin
      sof_frame_number <= microframe_index[`INDEX_MSB:`SOF_LSB];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      list_index <= `LIST_INDEX_WIDTH'(0);
    end else if (clock_enable) begin
      list_index <= list_bits(microframe_index, list_size_sel);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable and gating
  // ----------------------------------------------------------------
  logic [`IRQ_FIELD_WIDTH-1:0] next_irq_enable_mask;

  // Reserved bits are not stored
  always_comb begin
    next_irq_enable_mask = irq_enable_mask;
    if (write_mask) begin
      next_irq_enable_mask = request.write_data[`IRQ_FIELD_MSB:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      irq_enable_mask <= `RESET_ENABLE_MASK;
    end else begin
      irq_enable_mask <= next_irq_enable_mask;
    end
  end

  wire [`IRQ_FIELD_WIDTH-1:0] active = status_flags & irq_enable_mask;
  wire [`IRQ_FIELD_WIDTH-1:0] gated  = active & `THRESHOLD_GATED;

  wire [`IRQ_FIELD_WIDTH-1:0] immediate = active & ~`THRESHOLD_GATED;

  logic [`IRQ_FIELD_WIDTH-1:0] next_gated_pending;

  // held until flag or enable cleared
  // Latch on a tick, then drop once flag or enable clears
  always_comb begin
    next_gated_pending = gated_pending & gated;
    if (threshold_tick) begin
      next_gated_pending = gated;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gated_pending <= `RESET_ENABLE_MASK;
    end else if (clock_enable) begin
      gated_pending <= next_gated_pending;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt line
  // ----------------------------------------------------------------
  // enabled active source
  assign host_irq = (|immediate) || (|gated_pending);

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] mask_word  = {26'h0000000, irq_enable_mask};
  wire [31:0] index_word = {18'h00000, microframe_index};
  logic [31:0] read_mux;

  // Unmapped offsets read as zero
  always_comb begin
    read_mux = 32'h00000000;
    if (hit_mask) begin
      read_mux = mask_word;
    end else if (hit_index) begin
      read_mux = index_word;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      read_data  <= 32'h00000000;
      read_valid <= 1'b0;
    end else if (clock_enable) begin
      read_valid <= request.read;
      if (request.read) begin
        read_data <= read_mux;
      end
    end
  end

endmodule : usb_host_irq_enable_frame_index

// file: verilog/usb_host_irq_regs.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the package and design files by bare name
`ifndef USB_HOST_IRQ_REGS_SVH
`define USB_HOST_IRQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets from the controller base address
// ----------------------------------------------------------------
`define OFFSET_IRQ_ENABLE_MASK   8'h28
`define OFFSET_MICROFRAME_INDEX  8'h2C

// ----------------------------------------------------------------
// Enable mask and status flag bit positions
// ----------------------------------------------------------------
`define BIT_XFER_DONE      0
`define BIT_XFER_ERROR     1
`define BIT_PORT_CHANGE    2
`define BIT_ROLLOVER       3
`define BIT_SYSTEM_ERROR   4
`define BIT_ASYNC_ADVANCE  5
`define IRQ_FIELD_MSB      5
`define IRQ_FIELD_WIDTH    6
`define THRESHOLD_GATED    6'h23

// ----------------------------------------------------------------
// Frame index layout
// ----------------------------------------------------------------
`define INDEX_WIDTH        14
`define INDEX_MSB          13
`define SOF_LSB            3
`define SOF_WIDTH          11
`define LIST_INDEX_WIDTH   10
`define INDEX_MAX          14'h3FFF
`define RESET_ENABLE_MASK  6'h00
`define RESET_INDEX        14'h0000

// ----------------------------------------------------------------
// List size select codes and index top bits
// ----------------------------------------------------------------
`define LIST_SIZE_1024     2'h0
`define LIST_SIZE_512      2'h1
`define LIST_SIZE_256      2'h2
`define TOP_BIT_1024       12
`define TOP_BIT_512        11
`define TOP_BIT_256        10

// ----------------------------------------------------------------
// Microframe timing
// ----------------------------------------------------------------
`define MICROFRAME_NS      125000
`define CLOCK_PERIOD_NS    10
`define MICROFRAME_CYCLES  (`MICROFRAME_NS / `CLOCK_PERIOD_NS)

`endif

// file: verilog/usb_host_irq_pkg.sv
// Types shared by the interrupt-enable and frame-index block
// Assumes the constants header lies on the include path
`include "usb_host_irq_regs.svh"

package usb_host_irq_pkg;

  // Register bus request from host software
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byte_enable;
    logic [31:0] write_data;
  } reg_request_type;

  // Status flag sources, one bit per source
  typedef struct packed {
    logic async_advance_flag;
    logic system_error_flag;
    logic rollover_flag;
    logic port_change_flag;
    logic xfer_error_flag;
    logic xfer_done_flag;
  } irq_flags_type;

  // Frame counter state machine
  typedef enum logic [1:0] {
    counter_stopped = 2'b01,
    counter_running = 2'b10
  } counter_state_type;

endpackage : usb_host_irq_pkg

// file: verilog/microframe_timer.sv
// Microframe timer: one pulse at the end of every 125 us microframe
// Assumes a 100 MHz clock; counts only while enable and run are high
`timescale 1ns/1ps
`include "usb_host_irq_regs.svh"

module microframe_timer
  import usb_host_irq_pkg::*;
#(
  parameter logic [16:0] CYCLES = 17'(`MICROFRAME_CYCLES)
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic enable,
  input  wire logic run,
  output logic      frame_end
);

  logic [16:0] count;
  wire         last_cycle = (count == CYCLES - 17'h00001);

  assign frame_end = run && last_cycle;

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= 17'h00000;
    end else if (enable) begin
      if (!run || last_cycle) begin
        count <= 17'h00000;
      end else begin
        count <= count + 17'h00001;
      end
    end
  end

endmodule : microframe_timer

// file: tb/usb_host_irq_monitor.sv
// Checker for the enable mask and frame index block
// Assumes a bind onto the block top, one clock domain
`timescale 1ns/1ps
`include "usb_host_irq_regs.svh"
module usb_host_irq_monitor
  import usb_host_irq_pkg::*;
(
  input wire logic                        clock,
  input wire logic                        rst,
  input wire logic                        clock_enable,
  input wire reg_request_type             request,
  input wire logic [31:0]                 read_data,
  input wire logic                        read_valid,
  input wire irq_flags_type               status_flags,
  input wire logic                        run_stop,
  input wire logic [1:0]                  list_size_sel,
  input wire logic                        threshold_tick,
  input wire logic                        host_irq,
  input wire logic                        rollover_event,
  input wire logic [`SOF_WIDTH-1:0]        sof_frame_number,
  input wire logic [`LIST_INDEX_WIDTH-1:0] list_index,
  input wire logic                        microframe_end
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [5:0]  mask;
  logic [13:0] gap;
  logic        gap_ok;
  wire  [5:0]  act = status_flags & mask;
  wire         rd_req = clock_enable & request.read;
  // ----------------------------------------
  // Shadow of mask and microframe spacing
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (rst)
      mask <= 6'h00;
    else if (clock_enable && request.write && request.address == 8'h28)
      mask <= request.write_data[5:0];
    gap    <= microframe_end ? 14'h0000 : gap + 14'h0001;
    gap_ok <= (microframe_end | gap_ok) & run_stop & clock_enable & !rst;
  end
  property p_irq_now;
    |(act & 6'h1C) |-> host_irq;
  endproperty
  a_irq_now: assert property (p_irq_now) else $error("no immediate irq");
  property p_gate_wait;
    (act & 6'h1C) == 6'h00 && $past(act & 6'h23) == 6'h00 |-> !host_irq;
  endproperty
  a_gate_wait: assert property (p_gate_wait) else $error("early irq");
  property p_gate_fire;
    threshold_tick && (act & 6'h23) != 6'h00 ##1 (act & 6'h23) == $past(act & 6'h23)
      |-> host_irq;
  endproperty
  a_gate_fire: assert property (p_gate_fire) else $error("no irq on tick");
  property p_read_mask;
    rd_req && request.address == 8'h28 |=> read_valid && read_data == {26'h0, $past(mask)};
  endproperty
  a_read_mask: assert property (p_read_mask) else $error("mask read wrong");
  property p_read_index;
    rd_req && request.address == 8'h2C |=> read_valid && read_data[31:14] == 18'h0;
  endproperty
  a_read_index: assert property (p_read_index) else $error("index top bits set");
  property p_frame_gap;
    microframe_end && gap_ok |-> gap == 14'h30D3;
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("microframe length");
  property p_list;
    list_size_sel == $past(list_size_sel) |-> list_index == (list_size_sel == 2'h2 ?
      {2'h0, sof_frame_number[7:0]} : list_size_sel == 2'h1 ?
      {1'h0, sof_frame_number[8:0]} : sof_frame_number[9:0]);
  endproperty
  a_list: assert property (p_list) else $error("list index bits");
  property p_roll;
    rollover_event && clock_enable |=> list_index == 10'h000;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover off zero");
endmodule : usb_host_irq_monitor

// file: tb/usb_host_status_model.sv
// Status flags and halt state as host software sees them
// Assumes one-cycle raise and acknowledge masks from the bench
`timescale 1ns/1ps
module usb_host_status_model
  import usb_host_irq_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [5:0] raise,
  input  wire logic [5:0] ack,
  input  wire logic       rollover_event,
  input  wire logic       run_stop,
  output irq_flags_type   status_flags,
  output logic            halted_flag
);
  wire [5:0] sets = raise | {2'h0, rollover_event, 3'h0};
  always_ff @(posedge clock) begin
    if (rst)
      status_flags <= irq_flags_type'(6'h00);
    else
      status_flags <= irq_flags_type'((status_flags & ~ack) | sets);
    halted_flag <= rst | !run_stop;
  end
endmodule : usb_host_status_model

// file: tb/usb_host_irq_enable_frame_index_tb_top.sv
// Bench for the enable mask and frame index block
// Assumes the status model on the far side, default microframe length
`timescale 1ns/1ps
`include "usb_host_irq_regs.svh"
module usb_host_irq_enable_frame_index_tb_top;
  import usb_host_irq_pkg::*;
  logic clock, rst, clock_enable, read_valid, halted_flag, run_stop, threshold_tick;
  logic host_irq, rollover_event, microframe_end;
  logic [31:0] read_data;
  logic [1:0]  list_size_sel;
  logic [10:0] sof_frame_number;
  logic [9:0]  list_index;
  logic [5:0]  raise, ack;
  reg_request_type request;
  irq_flags_type   status_flags;
  int num_errors, comparisons, cycles, n;
  usb_host_irq_enable_frame_index i_usb_host_irq_enable_frame_index (.*);
  usb_host_status_model i_usb_host_status_model (.clock(clock), .rst(rst), .raise(raise),
    .ack(ack), .rollover_event(rollover_event), .run_stop(run_stop),
    .status_flags(status_flags), .halted_flag(halted_flag));
  always #5 clock = ~clock;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    request <= '{1'b0, 1'b1, a, be, d};
    @(posedge clock);
    request.write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    request <= '{1'b1, 1'b0, a, 4'hF, 32'h0};
    @(posedge clock);
    request.read <= 1'b0;
    #1;
    check({31'h0, read_valid}, 32'h1);
    check(read_data, exp);
  endtask : rd
  task automatic fl(input logic [5:0] r, input logic [5:0] k);
    @(posedge clock);
    raise <= r;
    ack <= k;
    @(posedge clock);
    raise <= 6'h00;
    ack <= 6'h00;
    #1;
  endtask : fl
  task automatic tick();
    @(posedge clock);
    threshold_tick <= 1'b1;
    @(posedge clock);
    threshold_tick <= 1'b0;
    #1;
  endtask : tick
  task automatic wait_end();
    n = 0;
    while (microframe_end !== 1'b1 && n < 13000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(32'(n < 13000), 32'h1);
  endtask : wait_end
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    {clock, clock_enable, rst} = 3'h3;
    {run_stop, threshold_tick, list_size_sel, raise, ack} = 16'h0000;
    request = '0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    wr(8'h28, 32'h3F, 4'hF);
    rd(8'h28, 32'h3F);
    for (int i = 0; i < 6; i++) begin
      fl(6'h01 << i, 6'h00);
      check({31'h0, host_irq}, 32'(i inside {2, 3, 4}));
      tick();
      check({31'h0, host_irq}, 32'h1);
      fl(6'h00, 6'h01 << i);
      #10;
      check({31'h0, host_irq}, 32'h0);
    end
    wr(8'h28, 32'h0, 4'hF);
    fl(6'h3F, 6'h00);
    tick();
    check({31'h0, host_irq}, 32'h0);
    check({26'h0, status_flags}, 32'h3F);
    fl(6'h00, 6'h3F);
    @(posedge clock) list_size_sel <= 2'h2;
    wr(8'h2C, 32'h7FF, 4'h1);
    rd(8'h2C, 32'h0);
    wr(8'h2C, 32'h7FF, 4'hF);
    rd(8'h2C, 32'h7FF);
    check(32'(list_index), 32'hFF);
    check(32'(sof_frame_number), 32'hFF);
    wr(8'h28, 32'h08, 4'hF);
    @(posedge clock) run_stop <= 1'b1;
    wait_end();
    #30;
    check(32'(sof_frame_number), 32'h100);
    check(32'(list_index), 32'h0);
    check({31'h0, status_flags.rollover_flag}, 32'h1);
    check({31'h0, host_irq}, 32'h1);
    @(posedge clock) list_size_sel <= 2'h0;
    rd(8'h2C, 32'h800);
    check(32'(list_index), 32'h100);
    wait_end();
    rd(8'h2C, 32'h801);
    wrap_up();
  end
endmodule : usb_host_irq_enable_frame_index_tb_top
bind usb_host_irq_enable_frame_index usb_host_irq_monitor i_usb_host_irq_monitor (
  .clock(clock), .rst(rst), .clock_enable(clock_enable), .request(request),
  .read_data(read_data), .read_valid(read_valid), .status_flags(status_flags),
  .run_stop(run_stop), .list_size_sel(list_size_sel), .threshold_tick(threshold_tick),
  .host_irq(host_irq), .rollover_event(rollover_event), .sof_frame_number(sof_frame_number),
  .list_index(list_index), .microframe_end(microframe_end));
